// ### src/dma_crc_debug.sv
`timescale 1ns/1ps
`default_nettype none
module dma_crc_debug #(
  parameter int chan_width = 3
) (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    nrst,
  // axi4-lite write address and data
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [4:0]              s_axi_awaddr,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  // axi4-lite write response
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  output logic [1:0]                   s_axi_bresp,
  // axi4-lite read
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  input  wire logic [4:0]              s_axi_araddr,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  // dma bus access observed by the engine
  input  wire dma_crc_pkg::access_type access,
  input  wire logic [31:0]             dest_start_addr,
  // destination side write
  output dma_crc_pkg::dest_write_type  dest_write,
  output logic                         route_active
);

  // ==========================================================
  // reset release
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ==========================================================
  // state
  logic                         aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
  logic [4:0]                   awaddr_q, awaddr_d;
  logic [31:0]                  wdata_q, wdata_d, rdata_q, rdata_d;
  logic [3:0]                   wstrb_q, wstrb_d;
  logic [1:0]                   bresp_q, bresp_d, rresp_q, rresp_d;
  logic                         last_dir_q, last_dir_d;
  logic [chan_width-1:0]        last_chan_q, last_chan_d;
  logic [31:0]                  last_addr_q, last_addr_d;
  logic [31:0]                  control_q, control_d, value_q, value_d, tap_q, tap_d;
  dma_crc_pkg::dest_write_type  dest_q, dest_d;
  logic                         route_q, route_d;

  // ==========================================================
  // control fields
  logic [1:0]  byte_order;
  logic        reorder, reflect, enable, append, ip_mode;
  logic [4:0]  poly_length_minus_one;
  logic [2:0]  chan_sel;
  assign byte_order = control_q[dma_crc_pkg::byte_order_lsb +: 2];
  assign reorder    = control_q[dma_crc_pkg::reorder_bit];
  assign reflect    = control_q[dma_crc_pkg::reflect_bit];
  assign poly_length_minus_one       = control_q[dma_crc_pkg::poly_length_minus_one_lsb +: 5];
  assign enable     = control_q[dma_crc_pkg::enable_bit];
  assign append     = control_q[dma_crc_pkg::append_bit];
  assign ip_mode    = control_q[dma_crc_pkg::type_bit];
  assign chan_sel   = control_q[dma_crc_pkg::chan_lsb +: 3];

  function automatic logic [31:0] swap(input logic [31:0] d, input logic [1:0] sel);
    case (dma_crc_pkg::byte_order_type'(sel))
      dma_crc_pkg::word_swap:      swap = {d[7:0], d[15:8], d[23:16], d[31:24]};
      dma_crc_pkg::half_swap:      swap = {d[15:0], d[31:16]};
      dma_crc_pkg::half_byte_swap: swap = {d[23:16], d[31:24], d[7:0], d[15:8]};
      default:                     swap = d;
    endcase
  endfunction

  // one lfsr step with per-stage feedback gating
  function automatic logic [31:0] lfsr_step(input logic [31:0] s, input logic b,
                                            input logic [31:0] taps, input logic [4:0] len);
    logic        fb;
    logic [31:0] n;
    fb = s[len] ^ b;
    n  = '0;
    for (int i = 0; i < 32; i++) begin
      if (i == 0)
        n[i] = fb;
      else
        n[i] = taps[i] ? (s[i-1] ^ fb) : s[i-1];
    end
    lfsr_step = n;
  endfunction

  // ==========================================================
  // crc datapath
  logic [31:0] ordered, refl, lfsr_next, sum_next, mask, value_view, final_view;
  logic [16:0] part;
  logic [15:0] hi_w, lo_w;
  logic        take;
  always_comb begin
    ordered = swap(access.data, byte_order);
    for (int i = 0; i < 32; i++)
      refl[i] = reflect ? ordered[31-i] : ordered[i];
    lfsr_next = value_q;
    for (int i = 31; i >= 0; i--)
      lfsr_next = lfsr_step(lfsr_next, refl[i], tap_q, poly_length_minus_one);
    // end-around carry folded twice
    hi_w = refl[31:16];
    lo_w = refl[15:0];
    part = {1'b0, value_q[15:0]} + {1'b0, hi_w};
    part = {1'b0, part[15:0]} + {16'h0000, part[16]};
    part = {1'b0, part[15:0]} + {1'b0, lo_w};
    part = {1'b0, part[15:0]} + {16'h0000, part[16]};
    sum_next = {16'h0000, part[15:0]};
    mask = '0;
    for (int i = 0; i < 32; i++)
      mask[i] = (5'(i) <= poly_length_minus_one);
    value_view = ip_mode ? {16'h0000, ~value_q[15:0]} : (value_q & mask);
    // the appended result must include the closing beat itself
    final_view = ip_mode ? {16'h0000, ~sum_next[15:0]} : (lfsr_next & mask);
  end
  assign take = access.valid && enable && (access.channel == chan_sel);

  // ==========================================================
  // bus and engine next state
  logic        wr_go;
  logic [31:0] wmask, wval;
  always_comb begin
    aw_d = aw_q; w_d = w_q; b_d = b_q; r_d = r_q;
    awaddr_d = awaddr_q; wdata_d = wdata_q; wstrb_d = wstrb_q;
    bresp_d = bresp_q; rresp_d = rresp_q; rdata_d = rdata_q;
    last_dir_d = last_dir_q; last_chan_d = last_chan_q; last_addr_d = last_addr_q;
    control_d = control_q; value_d = value_q; tap_d = tap_q;
    dest_d = '0;
    route_d = enable;
    wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    wval = '0;
    if (access.valid) begin
      last_dir_d  = access.is_read;
      last_chan_d = access.channel;
      last_addr_d = access.addr;
    end
    if (take) begin
      value_d = ip_mode ? sum_next : lfsr_next;
      if (!append)
        dest_d = '{1'b1, access.addr, reorder ? ordered : access.data};
      else if (access.last)
        dest_d = '{1'b1, dest_start_addr, final_view};
    end else if (access.valid && !access.is_read) begin
      dest_d = '{1'b1, access.addr, access.data};
    end
    // awready and wready drop while a response is pending
    if (s_axi_awvalid && !aw_q && !b_q) begin
      aw_d = 1'b1; awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_q && !b_q) begin
      w_d = 1'b1; wdata_d = s_axi_wdata; wstrb_d = s_axi_wstrb;
    end
    wr_go = aw_q && w_q && !b_q;
    if (wr_go) begin
      aw_d = 1'b0; w_d = 1'b0; b_d = 1'b1; bresp_d = dma_crc_pkg::axi_okay;
      case (awaddr_q[4:2])
        dma_crc_pkg::control_off[4:2]: begin
          wval = (control_q & ~wmask) | (wdata_q & wmask & dma_crc_pkg::control_writable);
          if (wval[dma_crc_pkg::reorder_bit])
            wval[dma_crc_pkg::append_bit] = 1'b0;
          control_d = wval;
        end
        dma_crc_pkg::value_off[4:2]: begin
          wval = (value_q & ~wmask) | (wdata_q & wmask);
          value_d = ip_mode ? {16'h0000, ~wval[15:0]} : wval;
        end
        dma_crc_pkg::tap_mask_off[4:2]: tap_d = (tap_q & ~wmask) | (wdata_q & wmask);
        dma_crc_pkg::status_off[4:2], dma_crc_pkg::address_off[4:2]: bresp_d = dma_crc_pkg::axi_slverr;
        default: bresp_d = dma_crc_pkg::axi_slverr;
      endcase
    end
    if (b_q && s_axi_bready)
      b_d = 1'b0;
    if (r_q && s_axi_rready)
      r_d = 1'b0;
    if (s_axi_arvalid && !r_q) begin
      r_d = 1'b1; rresp_d = dma_crc_pkg::axi_okay;
      case (s_axi_araddr[4:2])
        dma_crc_pkg::status_off[4:2]:   rdata_d = {28'h0000000, last_dir_q, last_chan_q};
        dma_crc_pkg::address_off[4:2]:  rdata_d = last_addr_q;
        dma_crc_pkg::control_off[4:2]:  rdata_d = control_q;
        dma_crc_pkg::value_off[4:2]:    rdata_d = value_view;
        dma_crc_pkg::tap_mask_off[4:2]: rdata_d = tap_q;
        default: begin
          rdata_d = '0; rresp_d = dma_crc_pkg::axi_slverr;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      aw_q <= 1'b0; w_q <= 1'b0; b_q <= 1'b0; r_q <= 1'b0;
      awaddr_q <= '0; wdata_q <= '0; wstrb_q <= '0;
      bresp_q <= '0; rresp_q <= '0; rdata_q <= '0;
      last_dir_q <= 1'b0; last_chan_q <= '0; last_addr_q <= '0;
      control_q <= dma_crc_pkg::reset_value;
      value_q <= dma_crc_pkg::reset_value;
      tap_q <= dma_crc_pkg::reset_value;
      dest_q <= '0; route_q <= 1'b0;
    end else begin
      aw_q <= aw_d; w_q <= w_d; b_q <= b_d; r_q <= r_d;
      awaddr_q <= awaddr_d; wdata_q <= wdata_d; wstrb_q <= wstrb_d;
      bresp_q <= bresp_d; rresp_q <= rresp_d; rdata_q <= rdata_d;
      last_dir_q <= last_dir_d; last_chan_q <= last_chan_d; last_addr_q <= last_addr_d;
      control_q <= control_d; value_q <= value_d; tap_q <= tap_d;
      dest_q <= dest_d; route_q <= route_d;
    end
  end

  // ==========================================================
  // outputs
  assign s_axi_awready = aw_q;
  assign s_axi_wready  = w_q;
  assign s_axi_bvalid  = b_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = r_q;
  assign s_axi_rvalid  = r_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign dest_write    = dest_q;
  assign route_active  = route_q;

endmodule
`default_nettype wire

// ### src/dma_crc_pkg.sv
// How it works
// - status bit: last access read=1, write=0
// - status field holds last active channel
// - read-only register captures last access address
// - status bits 31..4 read zero
// - byte order field selects data swap
// - write reorder applies swap to destination
// - bit reflect applies in both modes
// - poly length field ignored in checksum mode
// - enable routes assigned channel through engine
// - append: absorb only, write crc at end
// - no append: absorb and forward data
// - append refused while write reorder set
// - type bit picks checksum or lfsr
// - channel select assigns engine to channel
// - value write seeds; read masks above length
// - checksum mode: upper sixteen bits zero
// - checksum write is stored complemented, reads back as written
// - tap mask bits 31..1 gate feedback per stage; stage 0 always takes it
package dma_crc_pkg;

  // ==========================================================
  // register map
  localparam logic [4:0] status_off   = 5'h00;
  localparam logic [4:0] address_off  = 5'h04;
  localparam logic [4:0] control_off  = 5'h08;
  localparam logic [4:0] value_off    = 5'h0c;
  localparam logic [4:0] tap_mask_off = 5'h10;

  // ==========================================================
  // control field positions
  localparam int byte_order_lsb = 28;
  localparam int reorder_bit    = 27;
  localparam int reflect_bit    = 24;
  localparam int poly_length_minus_one_lsb       = 8;
  localparam int enable_bit     = 7;
  localparam int append_bit     = 6;
  localparam int type_bit       = 5;
  localparam int chan_lsb       = 0;
  localparam logic [31:0] control_writable = 32'h3900_1fe7;
  localparam logic [31:0] reset_value      = 32'h0000_0000;
  localparam logic [1:0] axi_okay   = 2'h0;
  localparam logic [1:0] axi_slverr = 2'h2;

  typedef enum logic [1:0] {
    no_swap, word_swap, half_swap, half_byte_swap
  } byte_order_type;

  typedef struct packed {
    logic       valid;
    logic       is_read;
    logic [2:0] channel;
    logic [31:0] addr;
    logic [31:0] data;
    logic       last;
  } access_type;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [31:0] data;
  } dest_write_type;

endpackage

// ### verification/dma_crc_debug_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module dma_crc_debug_assertions (
  // clock and reset
  input wire logic                        sys_clk,
  input wire logic                        nrst,
  // register bus
  input wire logic                        s_axi_awvalid,
  input wire logic                        s_axi_wvalid,
  input wire logic                        s_axi_bvalid,
  input wire logic                        s_axi_bready,
  input wire logic                        s_axi_arvalid,
  input wire logic [4:0]                  s_axi_araddr,
  input wire logic                        s_axi_rvalid,
  input wire logic                        s_axi_rready,
  input wire logic [31:0]                 s_axi_rdata,
  input wire logic [1:0]                  s_axi_rresp,
  // engine side
  input wire dma_crc_pkg::access_type     access,
  input wire dma_crc_pkg::dest_write_type dest_write,
  input wire logic                        route_active
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // ==========
  // sequences
  sequence pass_beat;
    access.valid && !access.is_read && !route_active;
  endsequence
  sequence wr_req;
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  endsequence
  // ==========
  // properties
  chk_write_passes: assert property (pass_beat |=> dest_write.valid &&
    dest_write.data == $past(access.data) && dest_write.addr == $past(access.addr)) else $error("beat not passed on");
  chk_read_silent: assert property (access.valid && access.is_read && !route_active |=> !dest_write.valid)
    else $error("read beat wrote destination");
  chk_idle_silent: assert property (!access.valid |=> !dest_write.valid) else $error("write without beat");
  chk_status_upper: assert property ($rose(s_axi_rvalid) && s_axi_araddr == 5'h00 |->
    s_axi_rdata[31:4] == 28'h0) else $error("status upper bits set");
  chk_unmapped_read: assert property ($rose(s_axi_rvalid) && s_axi_araddr == 5'h14 |->
    s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
  chk_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid) else $error("read late");
  chk_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
  chk_write_answer: assert property (wr_req |-> ##[1:3] s_axi_bvalid) else $error("write response late");
  chk_write_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
endmodule
`default_nettype wire

// ### verification/dma_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module dma_engine_model (
  // clock
  input wire logic                     sys_clk,
  // bus beats and channel setup
  output var dma_crc_pkg::access_type  access,
  output var logic [31:0]              dest_start_addr
);
  initial begin
    access = '0;
    dest_start_addr = 32'h0000_0100;
  end
  // called just after a rising edge; gap 0 keeps the next beat back to back
  task automatic beat(input logic rd, input logic [2:0] ch, input logic [31:0] ad, dv,
                      input logic lst, input int gap);
    access <= '{1'b1, rd, ch, ad, dv, lst};
    @(posedge sys_clk);
    if (gap > 0) begin
      // a released bus shows no stale value
      access <= '{1'b0, ~rd, ~ch, ~ad, ~dv, 1'b0};
      repeat (gap) @(posedge sys_clk);
    end
  endtask
endmodule
`default_nettype wire

// ### verification/dma_crc_debug_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dma_crc_debug_tb_top;
  logic sys_clk = 0, nrst = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, r;
  logic [4:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, d, a, v, w;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [2:0] ch;
  logic [64:0] e, exp_q[$];
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, route_active;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata, dest_start_addr;
  wire dma_crc_pkg::access_type access;
  wire dma_crc_pkg::dest_write_type dest_write;
  int fail_count = 0, compares = 0;
  integer seed = 39708;
  always #25 sys_clk = ~sys_clk;
  dma_crc_debug i_dut (.sys_clk, .nrst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .access,
    .dest_start_addr, .dest_write, .route_active);
  dma_engine_model i_eng (.sys_clk, .access, .dest_start_addr);
  // ==========
  // tasks
  task automatic check(input string n, input logic [31:0] s, x);
    compares++;
    if (s !== x) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [4:0] ad, input logic [31:0] v, input logic [1:0] er = 2'h0);
    @(posedge sys_clk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [4:0] ad, input logic [31:0] x, input logic [1:0] er = 2'h0,
                    input logic [31:0] m = 32'hffff_ffff);
    @(posedge sys_clk);
    s_axi_araddr <= ad;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    check("rdata", s_axi_rdata & m, x);
    check("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  function automatic logic [31:0] swap(input logic [31:0] v, input logic [1:0] o);
    case (o)
      2'h1: return {v[7:0], v[15:8], v[23:16], v[31:24]};
      2'h2: return {v[15:0], v[31:16]};
      2'h3: return {v[23:16], v[31:24], v[7:0], v[15:8]};
      default: return v;
    endcase
  endfunction
  // lfsr reference, msb of the word first, bit 0 always takes the feedback
  function automatic logic [31:0] crc_model(input logic [31:0] s, dv, t, input int n);
    for (int i = 31; i >= 0; i--)
      s = {s[30:0], 1'b0} ^ ({32{s[n] ^ dv[i]}} & (t | 32'h1));
    return s;
  endfunction
  function automatic logic [15:0] ocsum(input logic [15:0] s, input logic [31:0] dv);
    logic [16:0] p;
    p = {1'b0, s} + {1'b0, dv[31:16]};
    p = {1'b0, p[15:0]} + {16'h0000, p[16]};
    p = {1'b0, p[15:0]} + {1'b0, dv[15:0]};
    p = {1'b0, p[15:0]} + {16'h0000, p[16]};
    return p[15:0];
  endfunction
  // ==========
  // destination monitor
  always @(posedge sys_clk) if (dest_write.valid) begin
    if (exp_q.size() == 0) check("dest_extra", 32'h1, 32'h0);
    else begin
      e = exp_q.pop_front();
      check("dest_addr", dest_write.addr, e[63:32]);
      if (e[64]) check("dest_data", dest_write.data, e[31:0]);
    end
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    fail_count++;
    give_verdict();
  end
  // ==========
  // sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    for (int i = 0; i < 5; i++) rd(5'(i * 4), 32'h0);
    rd(5'h14, 32'h0, 2'h2);
    wr(5'h00, $random(seed), 2'h2);
    rd(5'h00, 32'h0);
    wr(5'h08, 32'hffff_ffff);
    rd(5'h08, 32'h3900_1fa7);
    wr(5'h08, 32'h0000_0700);
    wr(5'h0c, 32'hffff_ffff);
    rd(5'h0c, 32'h0000_00ff);
    wr(5'h08, 32'h0000_0020);
    rd(5'h0c, 32'h0, 2'h0, 32'hffff_0000);
    for (int i = 0; i < 6; i++) begin
      {r, ch} = 4'($random(seed));
      a = $random(seed) & 32'hffff_fffc;
      d = $random(seed);
      if (r) exp_q.push_back({1'b1, ~a & 32'hffff_fffc, ~d});
      i_eng.beat(~r, ~ch, ~a & 32'hffff_fffc, ~d, 1'b0, 0);
      if (!r) exp_q.push_back({1'b1, a, d});
      i_eng.beat(r, ch, a, d, 1'b0, 1 + i % 3);
      rd(5'h00, {28'h0, r, ch});
      rd(5'h04, a);
    end
    for (int i = 0; i < 8; i++) begin
      wr(5'h08, {2'h0, 2'(i), 1'(i >> 2), 19'h0, 8'h83});
      d = $random(seed);
      exp_q.push_back({1'b1, 32'h200, i >= 4 ? swap(d, 2'(i)) : d});
      i_eng.beat(1'b0, 3'h3, 32'h200, d, 1'b0, 0);
      exp_q.push_back({1'b1, 32'h300, d});
      i_eng.beat(1'b0, 3'h5, 32'h300, d, 1'b0, 2);
      check("route", {31'h0, route_active}, 32'h1);
    end
    wr(5'h08, 32'h0000_07c2);
    rd(5'h08, 32'h0000_07c2);
    a = $random(seed);
    wr(5'h10, a);
    v = $random(seed);
    wr(5'h0c, v);
    d = $random(seed);
    w = $random(seed);
    v = crc_model(crc_model(v, d, a, 7), w, a, 7);
    exp_q.push_back({1'b1, dest_start_addr, v & 32'h0000_00ff});
    i_eng.beat(1'b0, 3'h2, 32'h400, d, 1'b0, 0);
    i_eng.beat(1'b0, 3'h2, 32'h404, w, 1'b1, 3);
    check("pending", 32'(exp_q.size()), 32'h0);
    rd(5'h0c, v & 32'h0000_00ff);
    wr(5'h08, 32'h0000_00a2);
    wr(5'h0c, 32'h0000_0000);
    d = $random(seed);
    exp_q.push_back({1'b1, 32'h500, d});
    i_eng.beat(1'b0, 3'h2, 32'h500, d, 1'b0, 2);
    rd(5'h0c, {16'h0000, ~ocsum(16'hffff, d)});
    give_verdict();
  end
endmodule
bind dma_crc_debug dma_crc_debug_assertions i_chk (.sys_clk, .nrst, .s_axi_awvalid, .s_axi_wvalid,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .s_axi_rresp, .access, .dest_write, .route_active);
`default_nettype wire
